// *** hdl/ana_ident_ability_regs.sv ***
// Identifier, advertisement and partner ability words behind a
// serial management slave (clock and data pins).
// Assumes management clock well below the 40 MHz system clock,
// straps stable while reset is held, and a status block that pulses
// sts_rd_i whenever the status word is read.
`timescale 1ns/1ps

module ana_ident_ability_regs #(
  parameter logic [23:0] OUI = 24'h5a5a5a, // Arbitrary value
  parameter logic [5:0] MODEL = 6'h2a, // Arbitrary value
  parameter logic [3:0] REV = 4'h1, // Arbitrary value
  parameter logic [5:0] PRE_MIN = ana_pkg::ANA_PRE_MIN
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic [4:0] phy_addr_i,
  input wire ana_pkg::ana_strap_t strap_i,
  input wire logic an_complete_i,
  input wire logic [15:0] lp_page_i,
  input wire logic lp_page_vld_i,
  input wire logic lp_page_clr_i,
  input wire logic local_rf_i,
  input wire logic sts_rd_i,
  output logic [15:0] adv_word_o,
  output logic [15:0] lp_word_o,
  output logic rf_sts_o,
  output logic an_valid_o
);

  // ----------------------------------------------------------------
  // Types and declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_START,
    S_HDR,
    S_TA_RD,
    S_RD,
    S_TA_WR,
    S_WR,
    S_SKIP
  } ana_smi_state_t;

  ana_smi_state_t state_r;
  ana_smi_state_t state_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [5:0] ones_r;
  logic [5:0] ones_nxt;
  ana_pkg::ana_smi_hdr_t hdr_r;
  ana_pkg::ana_smi_hdr_t hdr_nxt;
  ana_pkg::ana_smi_hdr_t hdr_in_w;
  logic [15:0] dsh_r;
  logic [15:0] dsh_nxt;
  logic mdio_nxt;
  logic mdio_oe_nxt;
  logic wr_stb_r;
  logic wr_stb_nxt;
  logic mdc_d_r;
  logic [15:0] adv_r;
  logic [15:0] adv_rst_w;
  logic [15:0] rd_word_w;
  logic [15:0] id_high_w;
  logic [15:0] id_low_w;
  logic [11:0] pins_w;
  logic [11:0] pins_s;
  logic mdc_s;
  logic mdio_s;
  logic [4:0] phy_addr_s;
  ana_pkg::ana_strap_t strap_s;
  logic mdc_rise_w;
  logic pre_ok_w;
  logic addr_hit_w;
  logic op_rd_w;
  logic op_wr_w;
  logic adv_we_w;
  logic [5:0] ones_inc_w;
  logic [1:0] settle_r;
  logic strap_load_w;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  assign pins_w = {mdc_i, mdio_i, phy_addr_i, strap_i};

  ana_pin_sync #(
    .W(12)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .pin_i(pins_w),
    .sync_o(pins_s)
  );

  assign mdc_s = pins_s[11];
  assign mdio_s = pins_s[10];
  assign phy_addr_s = pins_s[9:5];
  assign strap_s = pins_s[4:0];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mdc_d_r <= 1'b0;
    end else begin
      mdc_d_r <= mdc_s;
    end
  end

  // Both sample and drive on the rising edge; the station samples
  // read data a full management period later, so no hold issue
  assign mdc_rise_w = mdc_s & ~mdc_d_r;

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  assign hdr_in_w = {hdr_r[10:0], mdio_s};
  assign addr_hit_w = (hdr_in_w.phyad == phy_addr_s);
  assign op_rd_w = (hdr_in_w.op == ana_pkg::ANA_OP_READ);
  assign op_wr_w = (hdr_in_w.op == ana_pkg::ANA_OP_WRITE);
  assign pre_ok_w = (ones_r >= PRE_MIN);
  assign ones_inc_w = (ones_r == 6'h3f) ? ones_r : ones_r + 6'h01;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign id_high_w = OUI[21:6];
  assign id_low_w = {OUI[5:0], MODEL, REV};

  // Words outside this set answer zero
  assign rd_word_w = (hdr_r.regad == ana_pkg::ANA_ADDR_ID_HIGH) ? id_high_w :
                     (hdr_r.regad == ana_pkg::ANA_ADDR_ID_LOW) ? id_low_w :
                     (hdr_r.regad == ana_pkg::ANA_ADDR_ADV) ? adv_r :
                     (hdr_r.regad == ana_pkg::ANA_ADDR_LP) ? lp_word_o :
                     16'h0000;

  // ----------------------------------------------------------------
  // Management state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ones_nxt = ones_r;
    hdr_nxt = hdr_r;
    dsh_nxt = dsh_r;
    mdio_nxt = mdio_o;
    mdio_oe_nxt = mdio_oe_o;
    wr_stb_nxt = 1'b0;
    if (mdc_rise_w) begin
      case (state_r)
        S_IDLE: begin
          if (mdio_s) begin
            ones_nxt = ones_inc_w;
          end else begin
            ones_nxt = 6'h00;
            if (pre_ok_w) begin
              state_nxt = S_START;
            end
          end
        end
        S_START: begin
          cnt_nxt = 5'h00;
          state_nxt = mdio_s ? S_HDR : S_IDLE;
        end
        S_HDR: begin
          hdr_nxt = hdr_in_w;
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == ana_pkg::ANA_HDR_BITS - 5'h01) begin
            cnt_nxt = 5'h00;
            if (addr_hit_w && op_rd_w) begin
              state_nxt = S_TA_RD;
            end else if (addr_hit_w && op_wr_w) begin
              state_nxt = S_TA_WR;
            end else begin
              state_nxt = S_SKIP;
            end
          end
        end
        S_TA_RD: begin
          // Second turnaround bit is driven low
          mdio_oe_nxt = 1'b1;
          mdio_nxt = 1'b0;
          dsh_nxt = rd_word_w;
          cnt_nxt = 5'h00;
          state_nxt = S_RD;
        end
        S_RD: begin
          if (cnt_r == ana_pkg::ANA_DATA_BITS) begin
            mdio_oe_nxt = 1'b0;
            mdio_nxt = 1'b0;
            state_nxt = S_IDLE;
          end else begin
            mdio_nxt = dsh_r[15];
            dsh_nxt = {dsh_r[14:0], 1'b0};
            cnt_nxt = cnt_r + 5'h01;
          end
        end
        S_TA_WR: begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == ana_pkg::ANA_TA_BITS - 5'h01) begin
            cnt_nxt = 5'h00;
            state_nxt = S_WR;
          end
        end
        S_WR: begin
          dsh_nxt = {dsh_r[14:0], mdio_s};
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == ana_pkg::ANA_DATA_BITS - 5'h01) begin
            wr_stb_nxt = 1'b1;
            state_nxt = S_IDLE;
          end
        end
        S_SKIP: begin
          // Frame for another device or with an op that is neither read nor write; stay off the line
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == ana_pkg::ANA_SKIP_BITS - 5'h01) begin
            state_nxt = S_IDLE;
          end
        end
        default: begin
          state_nxt = S_IDLE;
          mdio_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_r <= S_IDLE;
      cnt_r <= 5'h00;
      ones_r <= 6'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ones_r <= ones_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      hdr_r <= '0;
      dsh_r <= 16'h0000;
    end else begin
      hdr_r <= hdr_nxt;
      dsh_r <= dsh_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
      wr_stb_r <= 1'b0;
    end else begin
      mdio_o <= mdio_nxt;
      mdio_oe_o <= mdio_oe_nxt;
      wr_stb_r <= wr_stb_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Advertisement word
  // ----------------------------------------------------------------
  always_comb begin
    adv_rst_w = ana_pkg::ANA_ADV_SEL;
    adv_rst_w[ana_pkg::ANA_ADV_RF] = ana_pkg::ANA_ADV_RF_RST;
    adv_rst_w[ana_pkg::ANA_ADV_PAUSE] = strap_s.pause;
    adv_rst_w[ana_pkg::ANA_ADV_T4] = ana_pkg::ANA_ADV_T4_RST;
    adv_rst_w[ana_pkg::ANA_ADV_FD100] = strap_s.fd100;
    adv_rst_w[ana_pkg::ANA_ADV_HD100] = strap_s.hd100;
    adv_rst_w[ana_pkg::ANA_ADV_FD10] = strap_s.fd10;
    adv_rst_w[ana_pkg::ANA_ADV_HD10] = strap_s.hd10;
  end

  // Writes to words 2, 3 and 5 fall through with no effect
  assign adv_we_w = wr_stb_r && (hdr_r.regad == ana_pkg::ANA_ADDR_ADV);

  // Synchroniser lags the pins, so a short reset alone would load
  // unsettled straps; keep loading a few edges after release
  assign strap_load_w = !rst_n_i || (settle_r != 2'h3);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      settle_r <= 2'h0;
    end else if (settle_r != 2'h3) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  // Straps are loaded while reset is held and until settled
  always_ff @(posedge clk_sys_i) begin
    if (strap_load_w) begin
      adv_r <= adv_rst_w;
    end else if (adv_we_w) begin
      adv_r <= (dsh_r & ana_pkg::ANA_ADV_WR_MASK) | ana_pkg::ANA_ADV_SEL;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      adv_word_o <= 16'h0000;
    end else begin
      adv_word_o <= adv_r;
    end
  end

  // ----------------------------------------------------------------
  // Partner page and remote fault status
  // ----------------------------------------------------------------
  ana_lp_capture u_lp_capture (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .page_i(lp_page_i),
    .page_vld_i(lp_page_vld_i),
    .page_clr_i(lp_page_clr_i),
    .local_rf_i(local_rf_i),
    .sts_rd_i(sts_rd_i),
    .page_o(lp_word_o),
    .rf_sts_o(rf_sts_o)
  );

  // Tells the negotiation and status logic when both words hold meaning
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      an_valid_o <= 1'b0;
    end else begin
      an_valid_o <= an_complete_i;
    end
  end

endmodule

// *** hdl/ana_lp_capture.sv ***
// Partner base page store and remote fault status latch.
// Page strobes come from the negotiation logic on the same clock.
`timescale 1ns/1ps

module ana_lp_capture (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [15:0] page_i,
  input wire logic page_vld_i,
  input wire logic page_clr_i,
  input wire logic local_rf_i,
  input wire logic sts_rd_i,
  output logic [15:0] page_o,
  output logic rf_sts_o
);

  logic rf_cond_w;

  // Reserved partner bits never stored
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      page_o <= ana_pkg::ANA_LP_RST;
    end else if (page_vld_i) begin
      page_o <= page_i & ana_pkg::ANA_LP_KEEP_MASK;
    end else if (page_clr_i) begin
      page_o <= ana_pkg::ANA_LP_RST;
    end
  end

  assign rf_cond_w = page_o[ana_pkg::ANA_LP_RF] | local_rf_i;

  // Set wins over a read in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rf_sts_o <= 1'b0;
    end else if (rf_cond_w) begin
      rf_sts_o <= 1'b1;
    end else if (sts_rd_i) begin
      rf_sts_o <= 1'b0;
    end
  end

endmodule

// *** hdl/ana_pin_sync.sv ***
// Three-stage synchroniser for pin inputs.
// A bit's output changes once stages two and three agree.
`timescale 1ns/1ps

module ana_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] st1_r;
  logic [W-1:0] st2_r;
  logic [W-1:0] st3_r;
  logic [W-1:0] agree_w;

  // No reset: straps must flow through while reset is held
  assign agree_w = ~(st2_r ^ st3_r);

  always_ff @(posedge clk_sys_i) begin
    st1_r <= pin_i;
    st2_r <= st1_r;
    st3_r <= st2_r;
  end

  always_ff @(posedge clk_sys_i) begin
    sync_o <= (agree_w & st2_r) | (~agree_w & sync_o);
  end

endmodule

// *** hdl/ana_pkg.sv ***
// Constants, field layouts and carrier types of the negotiation
// identifier and ability register set.
// Assumes one 40 MHz system clock and a serial management link.
//
// Behaviour
// - Word 2 reads fixed identifier bits 3 to 18, earliest bit at top.
// - Word 3 reads identifier bits 19 to 24, model number, revision number.
// - Advertisement next-page bit always reads zero and ignores writes.
// - Advertisement bits 14, 12 and 11 read zero; station writes zero there.
// - Advertisement bit 13 is writable local remote fault flag, reset zero.
// - Advertisement bit 10 is writable pause flag, reset from a strap pin.
// - Advertisement bits 8 to 5 are writable speed/duplex flags, reset from straps.
// - Advertisement bit 9 is writable T4 flag, reset zero.
// - Advertisement bits 4 to 0 read fixed selector 00001.
// - Partner bit 15 shows partner next-page ability, reset zero.
// - Partner bit 14 shows partner acknowledge, reset zero.
// - Partner bit 13 shows partner remote fault and sets remote fault status.
// - Partner bits 12 to 10 always read zero.
// - Partner bits 9 to 5 show partner abilities, reset zero.
// - Partner bits 4 to 0 hold partner selector, reset zero.
// - Remote fault status latches high until condition gone and status read.
// - Both ability words count as valid only once negotiation is complete.

package ana_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ANA_ADDR_ID_HIGH = 5'h02;
  localparam logic [4:0] ANA_ADDR_ID_LOW = 5'h03;
  localparam logic [4:0] ANA_ADDR_ADV = 5'h04;
  localparam logic [4:0] ANA_ADDR_LP = 5'h05;

  // ----------------------------------------------------------------
  // Advertisement word fields
  // ----------------------------------------------------------------
  localparam int ANA_ADV_RF = 13;
  localparam int ANA_ADV_PAUSE = 10;
  localparam int ANA_ADV_T4 = 9;
  localparam int ANA_ADV_FD100 = 8;
  localparam int ANA_ADV_HD100 = 7;
  localparam int ANA_ADV_FD10 = 6;
  localparam int ANA_ADV_HD10 = 5;
  localparam logic [15:0] ANA_ADV_WR_MASK = 16'h27e0;
  localparam logic [15:0] ANA_ADV_SEL = 16'h0001;
  localparam logic ANA_ADV_RF_RST = 1'b0;
  localparam logic ANA_ADV_T4_RST = 1'b0;

  // ----------------------------------------------------------------
  // Partner ability word fields
  // ----------------------------------------------------------------
  localparam int ANA_LP_RF = 13;
  localparam logic [15:0] ANA_LP_KEEP_MASK = 16'he3ff;
  localparam logic [15:0] ANA_LP_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Management frame opcodes and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] ANA_OP_WRITE = 2'h1;
  localparam logic [1:0] ANA_OP_READ = 2'h2;
  localparam logic [4:0] ANA_HDR_BITS = 5'h0c;
  localparam logic [4:0] ANA_TA_BITS = 5'h02;
  localparam logic [4:0] ANA_DATA_BITS = 5'h10;
  localparam logic [4:0] ANA_SKIP_BITS = 5'h12;
  localparam logic [5:0] ANA_PRE_MIN = 6'h01;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pause;
    logic fd100;
    logic hd100;
    logic fd10;
    logic hd10;
  } ana_strap_t;

  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phyad;
    logic [4:0] regad;
  } ana_smi_hdr_t;

endpackage

// *** sim/ana_ident_ability_regs_chk.sv ***
// Port checker for the identifier and ability register set.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module ana_ident_ability_regs_chk (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic [4:0] phy_addr_i,
  input wire ana_pkg::ana_strap_t strap_i,
  input wire logic an_complete_i,
  input wire logic [15:0] lp_page_i,
  input wire logic lp_page_vld_i,
  input wire logic lp_page_clr_i,
  input wire logic local_rf_i,
  input wire logic sts_rd_i,
  input wire logic [15:0] adv_word_o,
  input wire logic [15:0] lp_word_o,
  input wire logic rf_sts_o,
  input wire logic an_valid_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_adv_fixed_zero;
    adv_word_o[15] == 1'b0 && adv_word_o[14] == 1'b0 && adv_word_o[12:11] == 2'h0;
  endproperty
  a_adv_fixed_zero: assert property (p_adv_fixed_zero) else $error("advertisement fixed zero bits set");
  property p_adv_sel;
    $past(rst_n_i) |-> adv_word_o[4:0] == 5'h01;
  endproperty
  a_adv_sel: assert property (p_adv_sel) else $error("advertisement selector wrong");
  property p_lp_rsv;
    lp_word_o[12:10] == 3'h0;
  endproperty
  a_lp_rsv: assert property (p_lp_rsv) else $error("partner reserved bits set");
  property p_lp_store;
    lp_page_vld_i |=> lp_word_o == ($past(lp_page_i) & 16'he3ff);
  endproperty
  a_lp_store: assert property (p_lp_store) else $error("partner page not stored");
  property p_lp_clr;
    lp_page_clr_i && !lp_page_vld_i |=> lp_word_o == 16'h0000;
  endproperty
  a_lp_clr: assert property (p_lp_clr) else $error("partner word not cleared");
  property p_lp_hold;
    !lp_page_vld_i && !lp_page_clr_i |=> $stable(lp_word_o);
  endproperty
  a_lp_hold: assert property (p_lp_hold) else $error("partner word changed by itself");
  property p_rf_partner;
    lp_word_o[13] |-> ##[0:1] rf_sts_o;
  endproperty
  a_rf_partner: assert property (p_rf_partner) else $error("partner fault not latched");
  property p_rf_local;
    local_rf_i |=> rf_sts_o;
  endproperty
  a_rf_local: assert property (p_rf_local) else $error("local fault not latched");
  property p_rf_hold;
    rf_sts_o && !sts_rd_i |=> rf_sts_o;
  endproperty
  a_rf_hold: assert property (p_rf_hold) else $error("fault status dropped unread");
  property p_rf_clr;
    rf_sts_o && sts_rd_i && !local_rf_i && !lp_word_o[13] && !lp_page_vld_i |=> !rf_sts_o;
  endproperty
  a_rf_clr: assert property (p_rf_clr) else $error("fault status not cleared by read");
  property p_an_valid;
    $past(rst_n_i) |-> an_valid_o == $past(an_complete_i);
  endproperty
  a_an_valid: assert property (p_an_valid) else $error("valid flag does not follow complete");
endmodule
bind ana_ident_ability_regs ana_ident_ability_regs_chk ana_ident_ability_regs_chk_i (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o),
  .mdio_oe_o(mdio_oe_o), .phy_addr_i(phy_addr_i), .strap_i(strap_i), .an_complete_i(an_complete_i),
  .lp_page_i(lp_page_i), .lp_page_vld_i(lp_page_vld_i), .lp_page_clr_i(lp_page_clr_i),
  .local_rf_i(local_rf_i), .sts_rd_i(sts_rd_i), .adv_word_o(adv_word_o), .lp_word_o(lp_word_o),
  .rf_sts_o(rf_sts_o), .an_valid_o(an_valid_o)
);

// *** sim/ana_mgmt_station.sv ***
// Management station model driving the serial management pins.
// Assumes a pull-up on the data line, resolved by the bench.
`timescale 1ns/1ps
module ana_mgmt_station (
  input wire logic clk_sys_i,
  input wire logic mdio_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b0;
    mdio_oe_o = 1'b0;
  end
  task automatic half();
    repeat (8) @(posedge clk_sys_i);
    #1;
  endtask
  // Sample just before the rise, when the device bit has long settled
  task automatic cyc(input logic oe, input logic b, output logic smp);
    mdio_oe_o = oe;
    if (oe) begin
      mdio_o = b;
    end
    half();
    smp = mdio_i;
    mdc_o = 1'b1;
    half();
    mdc_o = 1'b0;
  endtask
  // Data goes out as given; zero in reserved bits is the caller's job
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [32:0] seq;
    logic s;
    seq = {3'b101, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 34; i++) begin
      if (i < 15 || (op != ana_pkg::ANA_OP_READ && i < 33)) begin
        cyc(1'b1, seq[32-i], s);
      end else if (op == ana_pkg::ANA_OP_READ) begin
        cyc(1'b0, 1'b0, s);
        if (i >= 17 && i < 33) begin
          rd = {rd[14:0], s};
        end
      end
    end
    mdio_oe_o = 1'b0;
    // Clock stands still between frames
    half();
    half();
  endtask
endmodule

// *** sim/test_autoneg_ident_ability_regs.sv ***
// Self-checking bench for the identifier and ability register set.
// Assumes the station model and checker files are compiled before it.
`timescale 1ns/1ps
module test_autoneg_ident_ability_regs;
  localparam logic [23:0] OUI = 24'h3c96a5; // Arbitrary value
  localparam logic [5:0] MODEL = 6'h15; // Arbitrary value
  localparam logic [3:0] REV = 4'h7; // Arbitrary value
  localparam logic [4:0] PHY = 5'h03;
  localparam logic [1:0] RD = ana_pkg::ANA_OP_READ;
  localparam logic [1:0] WR = ana_pkg::ANA_OP_WRITE;
  logic clk_sys_i, rst_n_i, mdc, st_o, st_oe, mdio_o, mdio_oe_o, mdio_w;
  logic an_complete, lp_vld, lp_clr, local_rf, sts_rd, rf_sts, an_valid;
  logic [15:0] lp_page, adv_word, lp_word, d;
  ana_pkg::ana_strap_t strap;
  int errors, total_checks;
  assign mdio_w = mdio_oe_o ? mdio_o : (st_oe ? st_o : 1'b1);
  ana_ident_ability_regs #(.OUI(OUI), .MODEL(MODEL), .REV(REV)) ana_ident_ability_regs_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o), .phy_addr_i(PHY), .strap_i(strap), .an_complete_i(an_complete),
    .lp_page_i(lp_page), .lp_page_vld_i(lp_vld), .lp_page_clr_i(lp_clr), .local_rf_i(local_rf),
    .sts_rd_i(sts_rd), .adv_word_o(adv_word), .lp_word_o(lp_word), .rf_sts_o(rf_sts), .an_valid_o(an_valid));
  ana_mgmt_station ana_mgmt_station_i (.clk_sys_i(clk_sys_i), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(st_o),
    .mdio_oe_o(st_oe));
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic do_reset(input ana_pkg::ana_strap_t s);
    strap = s;
    tick(4);
    rst_n_i = 1'b0;
    tick(4);
    rst_n_i = 1'b1;
    tick(4);
  endtask
  task automatic t_ident_reset(input logic [15:0] exp_adv);
    ana_mgmt_station_i.frame(RD, PHY, 5'h02, 16'h0000, d);
    chk(d, OUI[21:6]);
    ana_mgmt_station_i.frame(RD, PHY, 5'h03, 16'h0000, d);
    chk(d, {OUI[5:0], MODEL, REV});
    ana_mgmt_station_i.frame(RD, PHY, 5'h04, 16'h0000, d);
    chk(d, exp_adv);
    chk(adv_word, exp_adv);
    ana_mgmt_station_i.frame(RD, PHY, 5'h05, 16'h0000, d);
    chk(d, 16'h0000);
  endtask
  task automatic t_adv_rw();
    ana_mgmt_station_i.frame(WR, PHY ^ 5'h01, 5'h04, 16'hffff, d);
    chk(adv_word, 16'h04c1);
    ana_mgmt_station_i.frame(WR, PHY, 5'h04, 16'hffff, d);
    ana_mgmt_station_i.frame(2'h0, PHY, 5'h04, 16'h0000, d);
    chk(adv_word, 16'h27e1);
    ana_mgmt_station_i.frame(RD, PHY, 5'h04, 16'h0000, d);
    chk(d, 16'h27e1);
    ana_mgmt_station_i.frame(WR, PHY, 5'h04, 16'h2000, d);
    chk(adv_word, 16'h2001);
  endtask
  task automatic t_ro_ignored();
    logic [15:0] exp [3];
    logic [4:0] ad [3];
    exp = '{OUI[21:6], {OUI[5:0], MODEL, REV}, 16'h0000};
    ad = '{5'h02, 5'h03, 5'h05};
    for (int i = 0; i < 3; i++) begin
      ana_mgmt_station_i.frame(WR, PHY, ad[i], 16'hffff, d);
      ana_mgmt_station_i.frame(RD, PHY, ad[i], 16'h0000, d);
      chk(d, exp[i]);
    end
    ana_mgmt_station_i.frame(RD, PHY ^ 5'h01, 5'h02, 16'h0000, d);
    chk(d, 16'hffff);
  endtask
  task automatic t_partner_fault();
    lp_page = 16'hffff;
    pulse(lp_vld);
    chk(lp_word, 16'he3ff);
    chk({15'h0000, rf_sts}, 16'h0001);
    ana_mgmt_station_i.frame(RD, PHY, 5'h05, 16'h0000, d);
    chk(d, 16'he3ff);
    pulse(sts_rd);
    chk({15'h0000, rf_sts}, 16'h0001);
    pulse(lp_clr);
    chk(lp_word, 16'h0000);
    chk({15'h0000, rf_sts}, 16'h0001);
    pulse(sts_rd);
    chk({15'h0000, rf_sts}, 16'h0000);
    lp_page = 16'h5ca5;
    pulse(lp_vld);
    chk(lp_word, 16'h40a5);
    chk({15'h0000, rf_sts}, 16'h0000);
  endtask
  task automatic t_local_fault_valid();
    local_rf = 1'b1;
    tick(2);
    local_rf = 1'b0;
    tick(2);
    chk({15'h0000, rf_sts}, 16'h0001);
    pulse(sts_rd);
    chk({15'h0000, rf_sts}, 16'h0000);
    an_complete = 1'b1;
    tick(2);
    chk({15'h0000, an_valid}, 16'h0001);
    an_complete = 1'b0;
    tick(2);
    chk({15'h0000, an_valid}, 16'h0000);
  endtask
  initial begin
    errors = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    strap = 5'b10110;
    {an_complete, lp_vld, lp_clr, local_rf, sts_rd} = 5'h00;
    lp_page = 16'h0000;
    tick(4);
    rst_n_i = 1'b1;
    tick(4);
    t_ident_reset(16'h04c1);
    t_adv_rw();
    t_ro_ignored();
    t_partner_fault();
    t_local_fault_valid();
    // Second reset with other straps must drop written bit 13 again
    do_reset(5'b01001);
    t_ident_reset(16'h0121);
    tally_and_finish();
  end
  initial begin
    #2ms;
    errors++;
    tally_and_finish();
  end
endmodule
